// *** core/touch_cdc_pkg.sv ***
// types shared by the touch controller configuration block
package touch_cdc_pkg;
	typedef enum logic [1:0] {
		MODE_FULL   = 2'b00,
		MODE_OFF_A  = 2'b01,
		MODE_SLEEP  = 2'b10,
		MODE_OFF_B  = 2'b11
	} power_state_type;

	typedef enum logic [2:0] {
		BUS_IDLE = 3'b000,
		BUS_RX   = 3'b001,
		BUS_ACK  = 3'b010,
		BUS_TX   = 3'b011,
		BUS_MACK = 3'b100
	} bus_state_type;

	typedef struct packed {
		logic       active;
		logic       low_power;
		logic [4:0] stage_count;
		logic [8:0] decimation;
		logic [1:0] bias_code;
		logic       excite_en;
		logic [7:0] cal_en;
		logic [4:0] active_skip;
		logic [1:0] sleep_skip;
	} cdc_config_type;
endpackage

// *** core/touch_cdc_power_cal_regs.sv ***
// power control and stage calibration registers behind a two-wire serial slave
`timescale 1ns/1ps
`include "touch_cdc_regs.svh"

module touch_cdc_power_cal_regs #(
	parameter int unsigned FULL_PERIOD_CYCLES = `FULL_PERIOD_MS * `NS_PER_MS / `CLK_PERIOD_NS,
	parameter int unsigned SLEEP_STEP_CYCLES  = `SLEEP_STEP_MS * `NS_PER_MS / `CLK_PERIOD_NS
) (
	input  wire logic                  core_clk,
	input  wire logic                  nrst,
	input  wire logic                  scl_i,
	input  wire logic                  sda_i,
	output logic                       sda_o,
	output logic                       sda_oe,
	input  wire logic                  irq_event,
	output logic                       irq_pin,
	output logic                       seq_start,
	output touch_cdc_pkg::cdc_config_type cfg
);
	import touch_cdc_pkg::*;
	// ***************************************************
	// pin synchronisers and bus conditions
	// ***************************************************
	logic          scl_meta, scl_sync, scl_prev;
	logic          sda_meta, sda_sync, sda_prev;
	logic          scl_rise, scl_fall, start_cond, stop_cond;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			scl_meta <= 1'b1;
			scl_sync <= 1'b1;
			scl_prev <= 1'b1;
			sda_meta <= 1'b1;
			sda_sync <= 1'b1;
			sda_prev <= 1'b1;
		end else begin
			scl_meta <= scl_i;
			scl_sync <= scl_meta;
			scl_prev <= scl_sync;
			sda_meta <= sda_i;
			sda_sync <= sda_meta;
			sda_prev <= sda_sync;
		end
	end

	assign scl_rise   = scl_sync && !scl_prev;
	assign scl_fall   = !scl_sync && scl_prev;
	assign start_cond = scl_sync && scl_prev && sda_prev && !sda_sync;
	assign stop_cond  = scl_sync && scl_prev && !sda_prev && sda_sync;
	assign sda_o      = 1'b0;
	// ***************************************************
	// serial slave
	// ***************************************************
	bus_state_type state_reg;
	logic [3:0]    bit_cnt_reg;
	logic [2:0]    byte_idx_reg;
	logic [7:0]    shift_reg;
	logic [7:0]    tx_reg;
	logic          tx_low_reg;
	logic          read_reg;
	logic [1:0]    ptr_hi_reg;
	logic [9:0]    ptr_reg;
	logic [7:0]    data_hi_reg;
	logic          wr_valid_reg;
	logic [9:0]    wr_addr_reg;
	logic [15:0]   wr_data_reg;
	logic [15:0]   power_reg;
	logic [15:0]   cal_reg;
	logic [15:0]   rd_cur;

	function automatic logic [15:0] read_word(input logic [9:0] addr);
		if (addr == `OFS_POWER_CONTROL)
			return power_reg;
		else if (addr == `OFS_STAGE_CAL)
			return cal_reg;
		else
			return 16'h0000;
	endfunction
	assign rd_cur = read_word(ptr_reg);

	// unmapped offsets read zero and swallow writes
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			state_reg    <= BUS_IDLE;
			bit_cnt_reg  <= 4'h0;
			byte_idx_reg <= 3'h0;
			shift_reg    <= 8'h00;
			tx_reg       <= 8'h00;
			tx_low_reg   <= 1'b0;
			read_reg     <= 1'b0;
			ptr_hi_reg   <= 2'h0;
			ptr_reg      <= 10'h000;
			data_hi_reg  <= 8'h00;
			wr_valid_reg <= 1'b0;
			wr_addr_reg  <= 10'h000;
			wr_data_reg  <= 16'h0000;
			sda_oe       <= 1'b0;
		end else begin
			wr_valid_reg <= 1'b0;
			if (start_cond) begin
				state_reg    <= BUS_RX;
				bit_cnt_reg  <= 4'h0;
				byte_idx_reg <= 3'h0;
				sda_oe       <= 1'b0;
			end else if (stop_cond) begin
				state_reg <= BUS_IDLE;
				sda_oe    <= 1'b0;
			end else begin
				case (state_reg)
				BUS_RX: begin
					if (scl_rise && bit_cnt_reg != 4'h8) begin
						shift_reg   <= {shift_reg[6:0], sda_sync};
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end else if (scl_fall && bit_cnt_reg == 4'h8) begin
						bit_cnt_reg <= 4'h0;
						if (byte_idx_reg == 3'h0 && shift_reg[7:3] != `BUS_ADDR_UPPER) begin
							state_reg <= BUS_IDLE;
						end else begin
							state_reg <= BUS_ACK;
							sda_oe    <= 1'b1;
							case (byte_idx_reg)
							3'h0: begin
								read_reg     <= shift_reg[0];
								tx_low_reg   <= 1'b0;
								byte_idx_reg <= 3'h1;
							end
							3'h1: begin
								ptr_hi_reg   <= shift_reg[1:0];
								byte_idx_reg <= 3'h2;
							end
							3'h2: begin
								ptr_reg      <= {ptr_hi_reg, shift_reg};
								byte_idx_reg <= 3'h3;
							end
							3'h3: begin
								data_hi_reg  <= shift_reg;
								byte_idx_reg <= 3'h4;
							end
							default: begin
								wr_valid_reg <= 1'b1;
								wr_addr_reg  <= ptr_reg;
								wr_data_reg  <= {data_hi_reg, shift_reg};
								ptr_reg      <= ptr_reg + 10'h001;
								byte_idx_reg <= 3'h3;
							end
							endcase
						end
					end
				end
				BUS_ACK: begin
					if (scl_fall) begin
						if (read_reg) begin
							state_reg <= BUS_TX;
							tx_reg    <= rd_cur[15:8];
							sda_oe    <= !rd_cur[15];
						end else begin
							state_reg <= BUS_RX;
							sda_oe    <= 1'b0;
						end
					end
				end
				BUS_TX: begin
					if (scl_fall) begin
						if (bit_cnt_reg == 4'h7) begin
							state_reg   <= BUS_MACK;
							bit_cnt_reg <= 4'h0;
							sda_oe      <= 1'b0;
						end else begin
							tx_reg      <= {tx_reg[6:0], 1'b0};
							sda_oe      <= !tx_reg[6];
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
						end
					end
				end
				BUS_MACK: begin
					if (scl_rise && sda_sync) begin
						state_reg <= BUS_IDLE;
					end else if (scl_fall) begin
						state_reg  <= BUS_TX;
						tx_low_reg <= !tx_low_reg;
						if (!tx_low_reg) begin
							tx_reg  <= rd_cur[7:0];
							sda_oe  <= !rd_cur[7];
							ptr_reg <= ptr_reg + 10'h001;
						end else begin
							tx_reg  <= rd_cur[15:8];
							sda_oe  <= !rd_cur[15];
						end
					end
				end
				default: begin
					sda_oe <= 1'b0;
				end
				endcase
			end
		end
	end
	// ***************************************************
	// register file
	// ***************************************************
	// soft reset wins over the rest of the word, so the bit never stores
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			power_reg <= `RST_POWER_CONTROL;
			cal_reg   <= `RST_STAGE_CAL;
		end else if (wr_valid_reg) begin
			if (wr_addr_reg == `OFS_POWER_CONTROL) begin
				if (wr_data_reg[`F_SOFT_RESET]) begin
					power_reg <= `RST_POWER_CONTROL;
					cal_reg   <= `RST_STAGE_CAL;
				end else begin
					power_reg <= wr_data_reg & `POWER_WRITE_MASK;
				end
			end else if (wr_addr_reg == `OFS_STAGE_CAL) begin
				cal_reg <= wr_data_reg;
			end
		end
	end
	// ***************************************************
	// decoded configuration and sequence timer
	// ***************************************************
	power_state_type mode;
	logic [31:0]     period;
	logic [31:0]     timer_reg;

	assign mode   = power_state_type'(power_reg[`F_MODE_HI:`F_MODE_LO]);
	assign period = (mode == MODE_SLEEP) ?
		32'(SLEEP_STEP_CYCLES * (32'(power_reg[`F_SLEEP_HI:`F_SLEEP_LO]) + 32'd1)) :
		32'(FULL_PERIOD_CYCLES);

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cfg <= '0;
		end else begin
			cfg.active      <= (mode == MODE_FULL) || (mode == MODE_SLEEP);
			cfg.low_power   <= (mode == MODE_SLEEP);
			cfg.stage_count <= {1'b0, power_reg[`F_STAGES_HI:`F_STAGES_LO]} + 5'h01;
			case (power_reg[`F_DECIM_HI:`F_DECIM_LO])
			2'b00:   cfg.decimation <= 9'h100;
			2'b01:   cfg.decimation <= 9'h080;
			default: cfg.decimation <= 9'h040;
			endcase
			cfg.bias_code   <= power_reg[`F_BIAS_HI:`F_BIAS_LO];
			cfg.excite_en   <= !power_reg[`F_EXCITE_OFF];
			cfg.cal_en      <= cal_reg[`F_CAL_EN_HI:`F_CAL_EN_LO];
			cfg.active_skip <= (5'h04 << cal_reg[`F_ACT_SKIP_HI:`F_ACT_SKIP_LO]) - 5'h01;
			cfg.sleep_skip  <= cal_reg[`F_SLP_SKIP_HI:`F_SLP_SKIP_LO];
		end
	end
	// a shortened interval fires and restarts from zero at once if the count is already past its end, rather than waiting out the old one
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			timer_reg <= 32'h0000_0000;
			seq_start <= 1'b0;
		end else if (mode == MODE_OFF_A || mode == MODE_OFF_B) begin
			timer_reg <= 32'h0000_0000;
			seq_start <= 1'b0;
		end else if (timer_reg >= period - 32'd1) begin
			timer_reg <= 32'h0000_0000;
			seq_start <= 1'b1;
		end else begin
			timer_reg <= timer_reg + 32'd1;
			seq_start <= 1'b0;
		end
	end
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			irq_pin <= 1'b1;
		end else begin
			irq_pin <= irq_event ~^ power_reg[`F_IRQ_LEVEL];
		end
	end
	// ***************************************************
	// assertions
	// ***************************************************
	sequence s_write_reset;
		wr_valid_reg && wr_addr_reg == `OFS_POWER_CONTROL && wr_data_reg[`F_SOFT_RESET];
	endsequence
	sequence s_regs_clear;
		power_reg == 16'h0000 && cal_reg == 16'h0000;
	endsequence
	sequence s_addr_byte_ok;
		state_reg == BUS_RX && scl_fall && bit_cnt_reg == 4'h8 && byte_idx_reg == 3'h0
			&& shift_reg[7:3] == `BUS_ADDR_UPPER && !start_cond && !stop_cond;
	endsequence
	property p_soft_reset;
		@(posedge core_clk) disable iff (!nrst) s_write_reset |=> s_regs_clear;
	endproperty
	a_soft_reset: assert property (p_soft_reset) else $error("soft reset incomplete");
	property p_addr_ack;
		@(posedge core_clk) disable iff (!nrst) s_addr_byte_ok |=> sda_oe && state_reg == BUS_ACK;
	endproperty
	a_addr_ack: assert property (p_addr_ack) else $error("matching address not acked");
	property p_shutdown_quiet;
		@(posedge core_clk) disable iff (!nrst)
			(mode == MODE_OFF_A || mode == MODE_OFF_B) ##1 !$changed(mode) |-> !seq_start;
	endproperty
	a_shutdown_quiet: assert property (p_shutdown_quiet) else $error("shutdown sequence");
	// cfg lags the register by one clock, so compare only once the word has held still
	property p_stage_count;
		@(posedge core_clk) disable iff (!nrst)
			1'b1 ##1 $stable(power_reg) |-> cfg.stage_count == 5'(power_reg[7:4]) + 5'h01;
	endproperty
	a_stage_count: assert property (p_stage_count) else $error("stage count wrong");
	property p_decimation;
		@(posedge core_clk) disable iff (!nrst)
			1'b1 ##1 $stable(power_reg) |-> cfg.decimation == (power_reg[9:8] == 2'b00 ? 9'h100 :
				power_reg[9:8] == 2'b01 ? 9'h080 : 9'h040);
	endproperty
	a_decimation: assert property (p_decimation) else $error("decimation wrong");
	property p_excite;
		@(posedge core_clk) disable iff (!nrst)
			1'b1 ##1 $stable(power_reg) |-> cfg.excite_en != power_reg[12];
	endproperty
	a_excite: assert property (p_excite) else $error("excitation gate wrong");
	property p_active_skip;
		@(posedge core_clk) disable iff (!nrst) cal_reg[13:12] == 2'b11 ##1 $stable(cal_reg)
			|-> cfg.active_skip == 5'h1f;
	endproperty
	a_active_skip: assert property (p_active_skip) else $error("full power skip wrong");
	property p_irq_level;
		@(posedge core_clk) disable iff (!nrst)
			irq_event && !power_reg[11] ##1 $stable(power_reg) |-> !irq_pin;
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");
endmodule

// *** core/touch_cdc_regs.svh ***
// offsets, field positions, reset values and timing counts of the touch controller registers
`ifndef TOUCH_CDC_REGS_SVH
`define TOUCH_CDC_REGS_SVH
`define OFS_POWER_CONTROL   10'h000
`define OFS_STAGE_CAL       10'h001
`define RST_POWER_CONTROL   16'h0000
`define RST_STAGE_CAL       16'h0000
`define POWER_WRITE_MASK    16'hdbff
`define BUS_ADDR_UPPER      5'h0b
`define F_MODE_HI           1
`define F_MODE_LO           0
`define F_SLEEP_HI          3
`define F_SLEEP_LO          2
`define F_STAGES_HI         7
`define F_STAGES_LO         4
`define F_DECIM_HI          9
`define F_DECIM_LO          8
`define F_SOFT_RESET        10
`define F_IRQ_LEVEL         11
`define F_EXCITE_OFF        12
`define F_BIAS_HI           15
`define F_BIAS_LO           14
`define F_CAL_EN_HI         7
`define F_CAL_EN_LO         0
`define F_ACT_SKIP_HI       13
`define F_ACT_SKIP_LO       12
`define F_SLP_SKIP_HI       15
`define F_SLP_SKIP_LO       14
`define CLK_PERIOD_NS       8
`define FULL_PERIOD_MS      36
`define SLEEP_STEP_MS       200
`define NS_PER_MS           1000000
`endif

// *** testbench/host_model.sv ***
// serial host model driving the two-wire register bus of the touch controller
`timescale 1ns/1ps
module host_model (
	input  wire logic core_clk,
	input  wire logic sda_line,
	output logic      scl,
	output logic      sda_low
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic half();
		repeat (10) @(posedge core_clk);
	endtask
	// long wait before scl rises: the device may still hold its ack low
	task automatic start();
		sda_low <= 1'b0;
		half();
		scl <= 1'b1;
		half();
		sda_low <= 1'b1;
		half();
		scl <= 1'b0;
	endtask
	task automatic stop();
		@(posedge core_clk);
		sda_low <= 1'b1;
		half();
		scl <= 1'b1;
		half();
		sda_low <= 1'b0;
		half();
	endtask
	// v high releases the line; line sampled at end of high phase
	task automatic bit_io(input logic v, output logic r);
		@(posedge core_clk);
		sda_low <= !v;
		half();
		scl <= 1'b1;
		half();
		r = sda_line;
		scl <= 1'b0;
	endtask
	task automatic put(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], r);
		end
		bit_io(1'b1, r);
		ack = !r;
	endtask
	task automatic get(input logic last, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			b[i] = r;
		end
		bit_io(last, r);
	endtask
	task automatic write(input logic [6:0] dev, input logic [15:0] ptr, input logic [15:0] d0,
		input logic [15:0] d1, input logic two, output logic ack);
		logic a;
		start();
		put({dev, 1'b0}, ack);
		if (ack) begin
			put(ptr[15:8], a);
			put(ptr[7:0], a);
			put(d0[15:8], a);
			put(d0[7:0], a);
			if (two) begin
				put(d1[15:8], a);
				put(d1[7:0], a);
			end
		end
		stop();
	endtask
	task automatic read(input logic [6:0] dev, input logic [15:0] ptr, output logic [15:0] r0,
		output logic [15:0] r1);
		logic a;
		start();
		put({dev, 1'b0}, a);
		put(ptr[15:8], a);
		put(ptr[7:0], a);
		start();
		put({dev, 1'b1}, a);
		get(1'b0, r0[15:8]);
		get(1'b0, r0[7:0]);
		get(1'b0, r1[15:8]);
		get(1'b1, r1[7:0]);
		stop();
	endtask
endmodule

// *** testbench/testbench.sv ***
// self-checking bench for the touch controller power and calibration registers
`timescale 1ns/1ps
`include "touch_cdc_regs.svh"
module testbench;
	import touch_cdc_pkg::*;
	localparam int unsigned FULL_P = 40;
	localparam int unsigned STEP_P = 100;
	logic           core_clk = 1'b0;
	logic           nrst = 1'b0;
	logic           irq_event = 1'b0;
	logic           scl, sda_low, sda_o, sda_oe, irq_pin, seq_start, sda_line;
	cdc_config_type cfg;
	int             n_fail = 0;
	int             compares = 0;
	int             cycles = 0;
	// pull-up on the data line; either side may only pull it low
	assign sda_line = !(sda_low || (sda_oe && !sda_o));
	always #4 core_clk = ~core_clk;
	touch_cdc_power_cal_regs #(.FULL_PERIOD_CYCLES(FULL_P), .SLEEP_STEP_CYCLES(STEP_P))
	i_touch_cdc_power_cal_regs (.core_clk(core_clk), .nrst(nrst), .scl_i(scl),
		.sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe), .irq_event(irq_event),
		.irq_pin(irq_pin), .seq_start(seq_start), .cfg(cfg));
	host_model i_host_model (.core_clk(core_clk), .sda_line(sda_line), .scl(scl),
		.sda_low(sda_low));
	task automatic stop_test();
		$display("compares %0d, n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			n_fail++;
			stop_test();
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: word %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_cfg(input cdc_config_type got, input cdc_config_type exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: config %h expected %h", $time, got, exp);
		end
	endtask
	function automatic cdc_config_type exp_cfg(input logic [15:0] p, input logic [15:0] c);
		cdc_config_type e;
		e.active = p[1:0] == 2'h0 || p[1:0] == 2'h2;
		e.low_power = p[1:0] == 2'h2;
		e.stage_count = {1'b0, p[7:4]} + 5'h01;
		e.decimation = p[9] ? 9'h040 : (p[8] ? 9'h080 : 9'h100);
		e.bias_code = p[15:14];
		e.excite_en = !p[12];
		e.cal_en = c[7:0];
		e.active_skip = 5'((6'h04 << c[13:12]) - 6'h01);
		e.sleep_skip = c[15:14];
		return e;
	endfunction
	function automatic logic [15:0] exp_gap(input logic [15:0] p);
		case (p[1:0])
			2'h0: return 16'(FULL_P);
			2'h2: return 16'(STEP_P * (p[3:2] + 1));
			default: return 16'h0000;
		endcase
	endfunction
	// cycles between two start pulses, zero when none comes
	task automatic gap(output logic [15:0] n);
		int k;
		k = 0;
		n = 16'h0000;
		while (!seq_start && k < 1000) begin
			@(posedge core_clk);
			k++;
		end
		if (seq_start) begin
			k = 0;
			do begin
				@(posedge core_clk);
				k++;
			end while (!seq_start && k < 1000);
			n = seq_start ? 16'(k) : 16'h0000;
		end
	endtask
	initial begin
		logic [15:0] p, c, r0, r1, n;
		logic [6:0]  dev;
		logic        ack;
		void'($urandom(32'he05d));
		repeat (4) @(posedge core_clk);
		nrst <= 1'b1;
		repeat (3) @(posedge core_clk);
		dev = {`BUS_ADDR_UPPER, 2'($urandom)};
		i_host_model.read(dev, 16'h0000, r0, r1);
		chk(r0, `RST_POWER_CONTROL);
		chk(r1, `RST_STAGE_CAL);
		chk_cfg(cfg, exp_cfg(16'h0000, 16'h0000));
		for (int i = 0; i < 4; i++) begin
			p = 16'($urandom);
			p[1:0] = 2'(i);
			p[3:2] = 2'(i);
			p[7:4] = (i == 3) ? 4'hb : 4'($urandom % 12);
			p[9:8] = 2'(i);
			p[10] = 1'b0;
			p[13] = 1'b0;
			p[15:14] = 2'(i);
			c = 16'($urandom);
			c[11:8] = 4'h0;
			c[13:12] = 2'(i);
			c[15:14] = 2'(i);
			i_host_model.write(dev, 16'h0000, p, c, 1'b1, ack);
			chk({15'h0000, ack}, 16'h0001);
			i_host_model.read(dev, 16'h0000, r0, r1);
			chk(r0, p);
			chk(r1, c);
			chk_cfg(cfg, exp_cfg(p, c));
			@(posedge core_clk);
			irq_event <= 1'($urandom);
			repeat (2) @(posedge core_clk);
			chk({15'h0000, irq_pin}, {15'h0000, p[11] ~^ irq_event});
			gap(n);
			chk(n, exp_gap(p));
		end
		// every wake interval code in low power mode
		for (int k = 0; k < 4; k++) begin
			p = 16'h0002 | 16'(k << 2);
			i_host_model.write(dev, 16'h0000, p, 16'h0000, 1'b0, ack);
			gap(n);
			chk(n, exp_gap(p));
		end
		// soft reset alone: a following word in the same burst would be stored again
		i_host_model.write(dev, 16'h0000, 16'h04b2, 16'h0000, 1'b0, ack);
		i_host_model.read(dev, 16'h0000, r0, r1);
		chk(r0, 16'h0000);
		chk(r1, 16'h0000);
		chk_cfg(cfg, exp_cfg(16'h0000, 16'h0000));
		i_host_model.write(dev, 16'h0005, 16'($urandom), 16'h0000, 1'b0, ack);
		i_host_model.read(dev, 16'h0005, r0, r1);
		chk(r0, 16'h0000);
		i_host_model.write({5'h0c, 2'h0}, 16'h0000, 16'h00b2, 16'h0000, 1'b0, ack);
		chk({15'h0000, ack}, 16'h0000);
		i_host_model.read(dev, 16'h0000, r0, r1);
		chk(r0, 16'h0000);
		stop_test();
	end
endmodule
